// >>> rtl/vin_ov_pkg.sv
// Shared constants and types for the input overvoltage fault response block.
// Assumes one 50 MHz core clock; volts are carried as unsigned fixed point, 8 fraction bits.
package vin_ov_pkg;

   // ************************************************************
   // Command codes and reset values
   // ************************************************************
   localparam logic [7:0]  CMD_OV_RESPONSE = 8'h56;
   localparam logic [7:0]  CMD_OV_WARN     = 8'h57;
   localparam logic [7:0]  RESP_RESET      = 8'h80;
   localparam logic [15:0] WARN_RESET      = 16'hD3E0;

   // ************************************************************
   // Field positions of the response byte
   // ************************************************************
   localparam int ACT_MSB   = 7;
   localparam int ACT_LSB   = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DELAY_MSB = 2;
   localparam int DELAY_LSB = 0;
   localparam logic [1:0] ACT_DISABLE_RETRY = 2'h2;
   localparam logic [2:0] RETRY_NONE        = 3'h0;

   // ************************************************************
   // Linear-11 layout and volt scaling
   // ************************************************************
   localparam int EXP_MSB   = 15;
   localparam int EXP_LSB   = 11;
   localparam int MANT_MSB  = 10;
   localparam int FRAC_BITS = 8;
   localparam int VIN_MAX_V = 18;
   localparam logic [33:0] VIN_MAX_CODE = 34'(VIN_MAX_V * (1 << FRAC_BITS));

   // ************************************************************
   // Retry timing
   // ************************************************************
   localparam int CLK_HZ        = 50_000_000;
   localparam int RETRY_UNIT_MS = 35;
   localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * (CLK_HZ / 1000);
   localparam int DIV_W         = 21;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {RUN_ST, WAIT_ST, LATCH_ST, STOP_ST} run_state_t;

   typedef struct packed {
      logic vin_ov_fault;    // Input status, fault bit
      logic vin_ov_warn;     // Input status, warning bit
      logic none_of_above;   // Status word
      logic input_sum;       // Status word, input summary
   } status_bits_t;

endpackage : vin_ov_pkg

// >>> rtl/linear11_decode.sv
// Linear-11 to fixed-point volts decoder with range check.
// Pure combinational; the caller registers whatever it keeps.
`timescale 1ns/10ps
`default_nettype none
module linear11_decode
   import vin_ov_pkg::*;
(
   // Encoded word
   input  wire logic [15:0] word_i,
   // Decoded value
   output logic      [15:0] volts_o,
   output logic             in_range_o
);

   logic signed [5:0] shift;
   logic        [33:0] mag;
   logic        [33:0] full;

   // Value is Y times two to the N, scaled by 2^8
   always_comb
   begin
      shift = $signed({word_i[EXP_MSB], word_i[EXP_MSB:EXP_LSB]}) + 6'sd8;
      mag   = {24'h000000, word_i[MANT_MSB-1:0]};
      if (shift >= 6'sd0)
         full = mag << shift[4:0];
      else
         full = mag >> 5'(-shift);
      volts_o    = full[15:0];
      // Negative mantissa lies below 0 V; large values above the limit
      in_range_o = !word_i[MANT_MSB] && (full <= VIN_MAX_CODE);
   end

endmodule : linear11_decode
`default_nettype wire

// >>> rtl/vin_ov_response.sv
// Input overvoltage fault response and warning for one power output.
// Assumes vin_meas_i, vin_ov_fault_i and the stop inputs come from core-clock logic.
//
// Functional notes
// - Response code 10 disables output, then retries.
// - Fault pulls alert low, sets fault bit.
// - Fault bits cleared only by clear-faults.
// - Retry mode 000 keeps output off.
// - Under code 10, nonzero retry mode restarts until stopped.
// - Restart only once input below warning.
// - Attempts spaced by (delay+1) times 35ms.
// - Above warning sets status bits, alerts host.
// - Out-of-range warning writes are refused.
// - Threshold is Linear-11, Y times 2^N.
`timescale 1ns/10ps
`default_nettype none
module vin_ov_response
   import vin_ov_pkg::*;
#(
   parameter int UNIT_CYCLES = RETRY_UNIT_CYC
)
(
   // Clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         reset_i,
   // Command write and read
   input  wire logic         cmd_wr_i,
   input  wire logic [7:0]   cmd_code_i,
   input  wire logic [15:0]  cmd_data_i,
   input  wire logic [7:0]   rd_code_i,
   input  wire logic         clear_faults_i,
   output logic      [15:0]  rd_data_o,
   output logic              wr_reject_o,
   // Measurement and fault detect
   input  wire logic [15:0]  vin_meas_i,
   input  wire logic         vin_ov_fault_i,
   // Stop conditions
   input  wire logic         cmd_off_i,
   input  wire logic         bias_lost_i,
   input  wire logic         other_fault_i,
   // Outputs
   output logic              output_on_o,
   output logic              alert_out_n_o,
   output var status_bits_t  status_o
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (UNIT_CYCLES < 1 || UNIT_CYCLES >= (1 << DIV_W))
      $error("UNIT_CYCLES out of range for the divider");

   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(UNIT_CYCLES - 1);

   typedef struct packed {
      run_state_t         st;
      logic [7:0]         resp;
      logic [15:0]        warn;
      status_bits_t       stat;
      logic [DIV_W-1:0]   div;
      logic [3:0]         units;
      logic [15:0]        rd_data;
      logic               reject;
      logic [31:0]        off_cyc;     // Cycles spent off; only the assertions read it
   } ovr_state_t;

   ovr_state_t st_ff;
   ovr_state_t nxt_st;

   logic [15:0] thr_volts;
   logic        wr_ok;
   logic        tick;
   logic        delay_done;
   logic        below_warn;
   logic        above_warn;
   logic        stop_req;

   // ************************************************************
   // Threshold decoders
   // ************************************************************
   linear11_decode thr_dec (
      .word_i     (st_ff.warn),
      .volts_o    (thr_volts),
      .in_range_o ()               // Stored word was range checked on write
   );

   linear11_decode wr_dec (
      .word_i     (cmd_data_i),
      .volts_o    (),              // Only the verdict of a write is needed
      .in_range_o (wr_ok)
   );

   // ************************************************************
   // Next-state logic
   // ************************************************************
   // Comparisons and retry pacing terms
   assign below_warn = vin_meas_i < thr_volts;
   assign above_warn = vin_meas_i > thr_volts;
   assign tick       = (st_ff.div == DIV_LAST);    // One 35ms step
   assign delay_done = st_ff.units >= ({1'b0, st_ff.resp[DELAY_MSB:DELAY_LSB]} + 4'h1);
   assign stop_req   = cmd_off_i | bias_lost_i | other_fault_i;

   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.reject = 1'b0;
      // Off-time count restarts whenever the output runs
      nxt_st.off_cyc = (st_ff.st == RUN_ST) ? 32'h0 : st_ff.off_cyc + 32'h1;

      // Settings writes; a bad threshold leaves the old one in place
      if (cmd_wr_i && cmd_code_i == CMD_OV_RESPONSE)
         nxt_st.resp = cmd_data_i[7:0];
      if (cmd_wr_i && cmd_code_i == CMD_OV_WARN)
      begin
         if (wr_ok)
            nxt_st.warn = cmd_data_i;
         else
            nxt_st.reject = 1'b1;
      end

      // Read mux, registered so data never glitches
      case (rd_code_i)
         CMD_OV_RESPONSE: nxt_st.rd_data = {8'h00, st_ff.resp};
         CMD_OV_WARN:     nxt_st.rd_data = st_ff.warn;
         default:         nxt_st.rd_data = 16'h0000;
      endcase

      // Sticky status; clear first so a same-cycle event wins
      if (clear_faults_i)
         nxt_st.stat = '0;
      if (vin_ov_fault_i)
      begin
         nxt_st.stat.vin_ov_fault  = 1'b1;
         nxt_st.stat.none_of_above = 1'b1;
         nxt_st.stat.input_sum     = 1'b1;
      end
      if (above_warn)
      begin
         nxt_st.stat.vin_ov_warn   = 1'b1;
         nxt_st.stat.none_of_above = 1'b1;
         nxt_st.stat.input_sum     = 1'b1;
      end

      // Retry pacing divider, free only while waiting
      if (st_ff.st == WAIT_ST)
      begin
         nxt_st.div = tick ? '0 : st_ff.div + 1'b1;
         if (tick && !delay_done)
            nxt_st.units = st_ff.units + 4'h1;
      end
      else
      begin
         nxt_st.div   = '0;
         nxt_st.units = 4'h0;
      end

      case (st_ff.st)
         RUN_ST:
         begin
            if (vin_ov_fault_i)
            begin
               // Unused action codes latch off like a no-retry setting
               if (st_ff.resp[ACT_MSB:ACT_LSB] == ACT_DISABLE_RETRY &&
                   st_ff.resp[RETRY_MSB:RETRY_LSB] != RETRY_NONE)
                  nxt_st.st = WAIT_ST;
               else
                  nxt_st.st = LATCH_ST;
            end
         end
         WAIT_ST:
         begin
            if (stop_req)
               nxt_st.st = STOP_ST;
            else if (delay_done && below_warn && !vin_ov_fault_i)
               nxt_st.st = RUN_ST;
         end
         LATCH_ST, STOP_ST:
         begin
            if (clear_faults_i)
               nxt_st.st = RUN_ST;
         end
         default: nxt_st.st = LATCH_ST;
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         st_ff      <= '0;
         st_ff.st   <= RUN_ST;
         st_ff.resp <= RESP_RESET;
         st_ff.warn <= WARN_RESET;
      end
      else
         st_ff <= nxt_st;
   end

   // Outputs; alert follows the sticky bits until cleared
   assign output_on_o   = (st_ff.st == RUN_ST);
   assign alert_out_n_o = !(st_ff.stat.vin_ov_fault | st_ff.stat.vin_ov_warn);
   assign status_o      = st_ff.stat;
   assign rd_data_o     = st_ff.rd_data;
   assign wr_reject_o   = st_ff.reject;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   fault_disables_a: assert property (st_ff.st == RUN_ST && vin_ov_fault_i |=> !output_on_o)
      else $error("fault did not disable output");
   fault_alert_a: assert property (vin_ov_fault_i |=> !alert_out_n_o && status_o.vin_ov_fault)
      else $error("fault did not raise alert");
   fault_sticky_a: assert property (status_o.vin_ov_fault && !clear_faults_i
                                    |=> status_o.vin_ov_fault)
      else $error("fault bit dropped without clear");
   latch_holds_a: assert property (st_ff.st == LATCH_ST && !clear_faults_i
                                   |=> st_ff.st == LATCH_ST && !output_on_o)
      else $error("latched output restarted");
   retry_continues_a: assert property (st_ff.st == WAIT_ST && !stop_req
                                       |=> st_ff.st inside {WAIT_ST, RUN_ST})
      else $error("retry abandoned without stop");
   restart_below_a: assert property (st_ff.st == WAIT_ST ##1 st_ff.st == RUN_ST
                                     |-> $past(below_warn))
      else $error("restart above warning level");
   retry_gap_a: assert property (st_ff.st == WAIT_ST && nxt_st.st == RUN_ST
      |-> st_ff.off_cyc >= 32'(({1'b0, st_ff.resp[DELAY_MSB:DELAY_LSB]} + 4'h1) * UNIT_CYCLES))
      else $error("restart before retry delay");
   warn_status_a: assert property (above_warn
      |=> status_o.vin_ov_warn && status_o.none_of_above && status_o.input_sum && !alert_out_n_o)
      else $error("warning bits not set");
   bad_write_a: assert property (cmd_wr_i && cmd_code_i == CMD_OV_WARN && !wr_ok
                                 |=> wr_reject_o && st_ff.warn == $past(st_ff.warn))
      else $error("bad threshold accepted");

   fault_seen_c:   cover property (st_ff.st == RUN_ST ##1 st_ff.st == WAIT_ST);
   restart_c:      cover property (st_ff.st == WAIT_ST ##1 st_ff.st == RUN_ST);
   latched_c:      cover property (st_ff.st == LATCH_ST ##1 st_ff.st == RUN_ST);
   reject_c:       cover property (wr_reject_o);

endmodule : vin_ov_response
`default_nettype wire

// >>> bench/vin_ov_host.sv
// Host stand-in for the fault response block: writes, reads, clear-faults.
// Assumes the bench clock; drives on the falling edge, one request at a time.
`timescale 1ns/10ps
`default_nettype none
module vin_ov_host
   import vin_ov_pkg::*;
(
   // Clock
   input  wire logic        core_clk_i,
   // Requests
   output logic             cmd_wr_o,
   output logic [7:0]       cmd_code_o,
   output logic [15:0]      cmd_data_o,
   output logic [7:0]       rd_code_o,
   output logic             clear_faults_o,
   // Answers
   input  wire logic [15:0] rd_data_i,
   input  wire logic        wr_reject_i
);
   // ****************************************
   // Bus tasks
   // ****************************************
   // Idle at time zero
   initial
   begin
      cmd_wr_o       = 1'b0;
      cmd_code_o     = 8'h00;
      cmd_data_o     = 16'h0000;
      rd_code_o      = 8'h00;
      clear_faults_o = 1'b0;
   end

   // One write strobe; refusal flag sampled one cycle later
   task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic rj);
   begin
      @(negedge core_clk_i);
      cmd_code_o = c;
      cmd_data_o = d;
      cmd_wr_o   = 1'b1;
      @(negedge core_clk_i);
      rj         = wr_reject_i;
      cmd_wr_o   = 1'b0;
      cmd_data_o = ~d; // Released data is not left looking valid
   end
   endtask : wr

   // Read answer is registered, so it lands one edge later
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
   begin
      @(negedge core_clk_i);
      rd_code_o = c;
      @(negedge core_clk_i);
      d = rd_data_i;
   end
   endtask : rd

   // Single clear-faults pulse
   task automatic clear();
   begin
      @(negedge core_clk_i);
      clear_faults_o = 1'b1;
      @(negedge core_clk_i);
      clear_faults_o = 1'b0;
   end
   endtask : clear
endmodule : vin_ov_host
`default_nettype wire

// >>> bench/vin_ov_response_bench.sv
// Self-checking bench for the input overvoltage fault response block.
// Assumes the package, the block and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) \
   begin \
      samples_checked++; \
      if ((s) !== (e)) \
      begin \
         failures++; \
         $display("unexpected %s exp %0h got %0h", nm, e, s); \
      end \
   end
module vin_ov_response_bench
   import vin_ov_pkg::*;
;
   localparam int U = 10;
   logic         clk = 1'b0;
   logic         reset = 1'b1;
   logic         wr, clr, rej, on, alert_n, rj, flt = 1'b0;
   logic [7:0]   code, rdc;
   logic [15:0]  data, rdd, rd_val, cur_w, vin = 16'h0000;
   logic [2:0]   stp = 3'h0;
   logic [7:0]   resp;
   status_bits_t st;
   int           failures = 0, samples_checked = 0, cyc = 0, thr, k, d;
   logic [15:0]  words [3] = '{16'h07FF, 16'h0013, 16'h0012};

   // ****************************************
   // Clock, instances, timeout
   // ****************************************
   // Half period of a 50 MHz clock
   always #10 clk = ~clk;

   vin_ov_response #(.UNIT_CYCLES(U)) u_dut
   (
      .core_clk_i(clk), .reset_i(reset), .cmd_wr_i(wr), .cmd_code_i(code),
      .cmd_data_i(data), .rd_code_i(rdc), .clear_faults_i(clr), .rd_data_o(rdd),
      .wr_reject_o(rej), .vin_meas_i(vin), .vin_ov_fault_i(flt), .cmd_off_i(stp[0]),
      .bias_lost_i(stp[1]), .other_fault_i(stp[2]), .output_on_o(on),
      .alert_out_n_o(alert_n), .status_o(st)
   );
   vin_ov_host u_host
   (
      .core_clk_i(clk), .cmd_wr_o(wr), .cmd_code_o(code), .cmd_data_o(data),
      .rd_code_o(rdc), .clear_faults_o(clr), .rd_data_i(rdd), .wr_reject_i(rej)
   );

   // Cycle ceiling so a hung wait still ends the run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
   begin
      if (failures == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask : report_and_stop

   // Model: Linear-11 word to volts*256, -1 when outside 0..18 V
   function automatic int l11(input logic [15:0] w);
      int n;
      int v;
   begin
      n = $signed(w[15:11]);
      v = $signed(w[10:0]) * 256;
      v = (n >= 0) ? (v <<< n) : (v >>> -n);
      return (v < 0 || v > 18 * 256) ? -1 : v;
   end
   endfunction : l11

   // Fault pulse, then count cycles until the output is back (cap 400)
   task automatic hit(output int n);
   begin
      @(negedge clk);
      flt = 1'b1;
      @(negedge clk);
      flt = 1'b0;
      n = 1;
      while (on !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
   end
   endtask : hit

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      void'($urandom(32'h797ED4ED));
      repeat (10) @(negedge clk);
      reset = 1'b0;
      u_host.rd(CMD_OV_RESPONSE, rd_val);
      `CHK("response", 16'h0080, rd_val)
      u_host.rd(CMD_OV_WARN, rd_val);
      `CHK("limit", 16'hD3E0, rd_val)
      cur_w = 16'hD3E0;
      // Negative and 19 V refused, 18 V exactly taken
      foreach (words[i])
      begin
         u_host.wr(CMD_OV_WARN, words[i], rj);
         `CHK("reject", 1'(l11(words[i]) < 0), rj)
         if (l11(words[i]) >= 0)
            cur_w = words[i];
         u_host.rd(CMD_OV_WARN, rd_val);
         `CHK("limit", cur_w, rd_val)
      end
      // Random quarter-volt limit, kept under any fault level
      cur_w = {5'h1E, 11'($urandom_range(72, 1))};
      u_host.wr(CMD_OV_WARN, cur_w, rj);
      thr = l11(cur_w);
      vin = 16'(thr);
      repeat (3) @(negedge clk);
      `CHK("status at limit", 4'h0, st)
      vin = 16'(thr + 1);
      repeat (3) @(negedge clk);
      `CHK("status above", 4'h7, st)
      `CHK("alert", 1'b0, alert_n)
      vin = 16'h0000;
      u_host.clear();
      `CHK("status cleared", 4'h0, st)
      // Action codes 00..11 with retry, then 10 without retry
      for (int a = 0; a < 5; a++)
      begin
         d = $urandom_range(7, 0);
         resp = (a == 4) ? {2'h2, 3'h0, 3'(d)} : {2'(a), 3'($urandom_range(7, 1)), 3'(d)};
         u_host.wr(CMD_OV_RESPONSE, {8'h00, resp}, rj);
         vin = 16'($urandom_range(thr - 1, 0));
         hit(k);
         `CHK("fault bit", 1'b1, st.vin_ov_fault)
         `CHK("alert", 1'b0, alert_n)
         if (a == 2)
            `CHK("spacing", 1'b1, 1'(k - 1 >= (d + 1) * U && k - 1 <= (d + 1) * U + 3))
         else
            `CHK("latched", 400, k)
         u_host.clear();
         `CHK("on after clear", 1'b1, on)
         `CHK("alert cleared", 1'b1, alert_n)
      end
      // Input above the limit holds the restart off
      u_host.wr(CMD_OV_RESPONSE, 16'h0098, rj);
      vin = 16'(thr + 16);
      hit(k);
      `CHK("held by input", 400, k)
      vin = 16'(thr - 1);
      repeat (4) @(negedge clk);
      `CHK("restart below", 1'b1, on)
      // Each stop input ends the retries
      for (int s = 0; s < 3; s++)
      begin
         @(negedge clk);
         flt = 1'b1;
         @(negedge clk);
         flt = 1'b0;
         stp = 3'(1 << s);
         repeat (40) @(negedge clk);
         `CHK("stopped", 1'b0, on)
         stp = 3'h0;
         u_host.clear();
         `CHK("on after stop", 1'b1, on)
      end
      report_and_stop();
   end
endmodule : vin_ov_response_bench
`default_nettype wire
